// ### hdl/smcd_pkg.sv
// constants, tables and types shared by both ends of the sector map detector link
// What this block does
// - first detector address word reads register 4
// - host masks second detector byte with 04h
// - host: bit clear bottom, set top
// - host uses current address length and latency
// - opcode 65h returns addressed register byte
// - second header: command descriptor, not end
// - header reserved fields always read ones
// - second detector address word reads register 2
// - host masks third detector byte with 02h
// - host: bit clear 64KB, set 256KB
// - host masks first detector bit 3
package smcd_pkg;
   // ----------------------------------------------------------------
   // link commands and framing
   // ----------------------------------------------------------------
   localparam logic [7:0] CMD_READ_ANY_REG = 8'h65;
   localparam logic [7:0] CMD_READ_TABLE = 8'h5A;
   localparam int ADDR_BITS = 24;
   localparam int DUMMY_BITS = 8;
   // dummy count kept a multiple of eight so data starts on a byte boundary
   localparam logic [6:0] HDR_BITS = 7'(8 + ADDR_BITS + DUMMY_BITS);
   localparam logic [6:0] RX_TABLE_BITS = 7'h40;
   localparam logic [6:0] RX_REG_BITS = 7'h08;
   localparam logic [3:0] SCK_HALF = 4'h8;

   // ----------------------------------------------------------------
   // descriptor layout
   // ----------------------------------------------------------------
   localparam int HDR_END_BIT = 0;
   localparam int HDR_MAP_BIT = 1;
   localparam int HDR_OP_LSB = 8;
   localparam int HDR_LAT_LSB = 16;
   localparam int HDR_LEN_LSB = 22;
   localparam int HDR_MASK_LSB = 24;
   localparam logic [1:0] LEN_CURRENT = 2'h3;
   localparam logic [3:0] LAT_CURRENT = 4'hF;
   localparam logic [7:0] DET_BASE = 8'h48;
   localparam logic [7:0] DET_BYTES = 8'h18;
   localparam logic [1:0] DET_LAST_IDX = 2'h2;
   localparam logic [7:0] TABLE_BLANK = 8'hFF;

   // detectors one to three, header then address word, low byte first
   localparam logic [7:0] DET_TABLE [0:23] = '{
      8'hFC, 8'h65, 8'hFF, 8'h08, 8'h04, 8'h00, 8'h00, 8'h00,
      8'hFC, 8'h65, 8'hFF, 8'h04, 8'h02, 8'h00, 8'h00, 8'h00,
      8'hFD, 8'h65, 8'hFF, 8'h02, 8'h04, 8'h00, 8'h00, 8'h00
   };

   // ----------------------------------------------------------------
   // device registers reachable with the register read command
   // ----------------------------------------------------------------
   localparam logic [23:0] REG_FIRST_CFG_ADDR = 24'h000002;
   localparam logic [23:0] REG_THIRD_CFG_ADDR = 24'h000004;
   localparam logic [7:0] CFG_RESET = 8'h00;
   localparam logic [7:0] REG_UNMAPPED = 8'h00;

   // ----------------------------------------------------------------
   // host wishbone registers
   // ----------------------------------------------------------------
   localparam logic [7:0] WB_CTRL = 8'h00;
   localparam logic [7:0] WB_STATUS = 8'h04;
   localparam logic [7:0] WB_RESULT = 8'h08;
   localparam logic [7:0] WB_DESC_HDR = 8'h0C;
   localparam logic [7:0] WB_DESC_ADDR = 8'h10;
   localparam int CTRL_START_BIT = 0;

   typedef enum logic [2:0] {
      SH_IDLE, SH_FETCH, SH_FETCH_WAIT, SH_CHECK, SH_QUERY_WAIT, SH_EVAL, SH_DONE
   } smcd_host_state_e;
endpackage : smcd_pkg

// ### hdl/smcd_link_if.sv
// serial link between the detector host and the flash device
`timescale 1ns/100ps
interface smcd_link_if;
   logic sclk;
   logic cs_n;
   logic mosi;
   logic miso;
   logic miso_oe;

   modport host (
      output sclk,
      output cs_n,
      output mosi,
      input miso,
      input miso_oe
   );

   modport device (
      input sclk,
      input cs_n,
      input mosi,
      output miso,
      output miso_oe
   );
endinterface : smcd_link_if

// ### hdl/smcd_desc_rom.sv
// discoverable parameter bytes holding the configuration detection descriptors
`timescale 1ns/100ps
module smcd_desc_rom import smcd_pkg::*; (
   input wire logic [23:0] offset_i,
   output logic [7:0] byte_o
);
   logic [23:0] rel;

   assign rel = offset_i - {16'h0000, DET_BASE};

   // header reserved fields and descriptor flags fixed in the table
   always_comb begin
      if (rel < {16'h0000, DET_BYTES}) begin
         byte_o = DET_TABLE[rel[4:0]];
      end else begin
         byte_o = TABLE_BLANK;
      end
   end
endmodule : smcd_desc_rom

// ### hdl/smcd_device.sv
// flash device end: parameter table and register read commands
`timescale 1ns/100ps
module smcd_device import smcd_pkg::*; (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic cfg_load_i,
   input wire logic [7:0] first_cfg_i,
   input wire logic [7:0] third_cfg_i,
   output logic [7:0] last_opcode_o,
   output logic selected_o,
   smcd_link_if.device link
);
   logic sclk_meta_ff, sclk_sync_ff, sclk_prev_ff;
   logic cs_meta_ff, cs_sync_ff;
   logic mosi_meta_ff, mosi_sync_ff;
   logic [6:0] bit_cnt_ff;
   logic [31:0] in_sr_ff;
   logic [7:0] opcode_ff;
   logic [23:0] addr_ff;
   logic [7:0] out_sr_ff;
   logic miso_ff, miso_oe_ff;
   logic [7:0] first_cfg_ff, third_cfg_ff;
   logic [7:0] rom_byte, src_byte;
   logic rise, fall, known_cmd;

   // ----------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      sclk_meta_ff <= link.sclk;
      sclk_sync_ff <= sclk_meta_ff;
      sclk_prev_ff <= sclk_sync_ff;
      cs_meta_ff <= link.cs_n;
      cs_sync_ff <= cs_meta_ff;
      mosi_meta_ff <= link.mosi;
      mosi_sync_ff <= mosi_meta_ff;
   end

   assign rise = sclk_sync_ff & ~sclk_prev_ff;
   assign fall = ~sclk_sync_ff & sclk_prev_ff;

   // ----------------------------------------------------------------
   // configuration registers
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         first_cfg_ff <= CFG_RESET;
         third_cfg_ff <= CFG_RESET;
      end else if (cfg_load_i) begin
         first_cfg_ff <= first_cfg_i;
         third_cfg_ff <= third_cfg_i;
      end
   end

   smcd_desc_rom smcd_desc_rom_i (
      .offset_i(addr_ff),
      .byte_o(rom_byte)
   );

   always_comb begin
      known_cmd = 1'b1;
      src_byte = REG_UNMAPPED;
      if (opcode_ff == CMD_READ_ANY_REG) begin
         if (addr_ff == REG_FIRST_CFG_ADDR) begin
            src_byte = first_cfg_ff;
         end else if (addr_ff == REG_THIRD_CFG_ADDR) begin
            src_byte = third_cfg_ff;
         end
      end else if (opcode_ff == CMD_READ_TABLE) begin
         src_byte = rom_byte;
      end else begin
         known_cmd = 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // command decode and data shifter
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i || cs_sync_ff) begin
         bit_cnt_ff <= 7'h00;
         in_sr_ff <= 32'h00000000;
         opcode_ff <= 8'h00;
         addr_ff <= 24'h000000;
         out_sr_ff <= 8'h00;
         miso_ff <= 1'b0;
         miso_oe_ff <= 1'b0;
      end else begin
         if (rise) begin
            in_sr_ff <= {in_sr_ff[30:0], mosi_sync_ff};
            if (bit_cnt_ff != 7'h7F) begin
               bit_cnt_ff <= bit_cnt_ff + 7'h01;
            end
            if (bit_cnt_ff == 7'h07) begin
               opcode_ff <= {in_sr_ff[6:0], mosi_sync_ff};
            end
            if (bit_cnt_ff == 7'h1F) begin
               addr_ff <= {in_sr_ff[22:0], mosi_sync_ff};
            end
         end
         // data changes on the falling edge so the host samples it settled
         if (fall && bit_cnt_ff >= HDR_BITS && known_cmd) begin
            miso_oe_ff <= 1'b1;
            if (bit_cnt_ff[2:0] == 3'h0) begin
               miso_ff <= src_byte[7];
               out_sr_ff <= {src_byte[6:0], 1'b0};
               addr_ff <= addr_ff + 24'h000001;
            end else begin
               miso_ff <= out_sr_ff[7];
               out_sr_ff <= {out_sr_ff[6:0], 1'b0};
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // user side status
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         last_opcode_o <= 8'h00;
         selected_o <= 1'b0;
      end else begin
         selected_o <= ~cs_sync_ff;
         if (rise && !cs_sync_ff && bit_cnt_ff == 7'h07) begin
            last_opcode_o <= {in_sr_ff[6:0], mosi_sync_ff};
         end
      end
   end

   assign link.miso = miso_ff;
   assign link.miso_oe = miso_oe_ff;
endmodule : smcd_device

// ### hdl/smcd_host.sv
// host end: walks the detection descriptors and reports the sector map choice
`timescale 1ns/100ps
module smcd_host import smcd_pkg::*; (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   smcd_link_if.host link
);
   // link engine
   logic sclk_ff, cs_n_ff, mosi_ff;
   logic miso_meta_ff, miso_sync_ff;
   logic busy_ff, ending_ff, xfer_done_ff;
   logic [3:0] half_cnt_ff;
   logic [6:0] rise_cnt_ff, rise_total_ff;
   logic [31:0] tx_sr_ff;
   logic [63:0] rx_sr_ff;
   // sequencer
   smcd_host_state_e state_ff;
   logic xfer_go_ff;
   logic [7:0] xfer_op_ff;
   logic [23:0] xfer_addr_ff;
   logic [6:0] xfer_rx_bits_ff;
   logic [1:0] det_idx_ff;
   logic [1:0] det_count_ff;
   logic [31:0] hdr_ff, desc_addr_ff;
   logic sel_bit_ff;
   logic [2:0] cfg_id_ff;
   logic hybrid_uniform_select_ff, param_sector_top_select_ff, uniform_block_size_select_ff;
   logic done_ff, err_ff;
   logic start_req;
   logic hdr_ok;

   // ----------------------------------------------------------------
   // miso synchroniser
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      miso_meta_ff <= link.miso;
      miso_sync_ff <= miso_meta_ff;
   end

   // ----------------------------------------------------------------
   // serial engine, mode 0, msb first
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sclk_ff <= 1'b0;
         cs_n_ff <= 1'b1;
         mosi_ff <= 1'b0;
         busy_ff <= 1'b0;
         ending_ff <= 1'b0;
         xfer_done_ff <= 1'b0;
         half_cnt_ff <= 4'h0;
         rise_cnt_ff <= 7'h00;
         rise_total_ff <= 7'h00;
         tx_sr_ff <= 32'h00000000;
         rx_sr_ff <= 64'h0000000000000000;
      end else begin
         xfer_done_ff <= 1'b0;
         if (!busy_ff) begin
            if (xfer_go_ff) begin
               busy_ff <= 1'b1;
               cs_n_ff <= 1'b0;
               mosi_ff <= xfer_op_ff[7];
               tx_sr_ff <= {xfer_op_ff[6:0], xfer_addr_ff, 1'b0};
               half_cnt_ff <= 4'h0;
               rise_cnt_ff <= 7'h00;
               rise_total_ff <= HDR_BITS + xfer_rx_bits_ff;
            end
         end else if (half_cnt_ff != SCK_HALF - 4'h1) begin
            half_cnt_ff <= half_cnt_ff + 4'h1;
         end else begin
            half_cnt_ff <= 4'h0;
            if (ending_ff) begin
               // chip select stays high a full half period before the next frame
               ending_ff <= 1'b0;
               busy_ff <= 1'b0;
               xfer_done_ff <= 1'b1;
            end else if (sclk_ff) begin
               sclk_ff <= 1'b0;
               mosi_ff <= tx_sr_ff[31];
               tx_sr_ff <= {tx_sr_ff[30:0], 1'b0};
            end else if (rise_cnt_ff == rise_total_ff) begin
               cs_n_ff <= 1'b1;
               mosi_ff <= 1'b0;
               ending_ff <= 1'b1;
            end else begin
               sclk_ff <= 1'b1;
               rise_cnt_ff <= rise_cnt_ff + 7'h01;
               if (rise_cnt_ff >= HDR_BITS) begin
                  rx_sr_ff <= {rx_sr_ff[62:0], miso_sync_ff};
               end
            end
         end
      end
   end

   assign link.sclk = sclk_ff;
   assign link.cs_n = cs_n_ff;
   assign link.mosi = mosi_ff;

   // ----------------------------------------------------------------
   // descriptor checks
   // ----------------------------------------------------------------
   // only current length and current latency descriptors can be served
   assign hdr_ok = !hdr_ff[HDR_MAP_BIT]
      && hdr_ff[HDR_OP_LSB +: 8] == CMD_READ_ANY_REG
      && hdr_ff[HDR_LEN_LSB +: 2] == LEN_CURRENT
      && hdr_ff[HDR_LAT_LSB +: 4] == LAT_CURRENT;

   assign start_req = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o
      && wb_adr_i == WB_CTRL && wb_sel_i[0] && wb_dat_i[CTRL_START_BIT];

   // ----------------------------------------------------------------
   // detection sequencer
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_ff <= SH_IDLE;
         xfer_go_ff <= 1'b0;
         xfer_op_ff <= 8'h00;
         xfer_addr_ff <= 24'h000000;
         xfer_rx_bits_ff <= 7'h00;
         det_idx_ff <= 2'h0;
         det_count_ff <= 2'h0;
         hdr_ff <= 32'h00000000;
         desc_addr_ff <= 32'h00000000;
         sel_bit_ff <= 1'b0;
         cfg_id_ff <= 3'h0;
         hybrid_uniform_select_ff <= 1'b0;
         param_sector_top_select_ff <= 1'b0;
         uniform_block_size_select_ff <= 1'b0;
         done_ff <= 1'b0;
         err_ff <= 1'b0;
      end else begin
         xfer_go_ff <= 1'b0;
         case (state_ff)
            SH_IDLE: begin
               if (start_req) begin
                  det_idx_ff <= 2'h0;
                  det_count_ff <= 2'h0;
                  cfg_id_ff <= 3'h0;
                  done_ff <= 1'b0;
                  err_ff <= 1'b0;
                  state_ff <= SH_FETCH;
               end
            end
            SH_FETCH: begin
               xfer_go_ff <= 1'b1;
               xfer_op_ff <= CMD_READ_TABLE;
               xfer_addr_ff <= {16'h0000, DET_BASE + {3'h0, det_idx_ff, 3'h0}};
               xfer_rx_bits_ff <= RX_TABLE_BITS;
               state_ff <= SH_FETCH_WAIT;
            end
            SH_FETCH_WAIT: begin
               if (xfer_done_ff) begin
                  hdr_ff <= {rx_sr_ff[39:32], rx_sr_ff[47:40], rx_sr_ff[55:48], rx_sr_ff[63:56]};
                  desc_addr_ff <= {rx_sr_ff[7:0], rx_sr_ff[15:8], rx_sr_ff[23:16], rx_sr_ff[31:24]};
                  state_ff <= SH_CHECK;
               end
            end
            SH_CHECK: begin
               if (hdr_ok) begin
                  xfer_go_ff <= 1'b1;
                  xfer_op_ff <= hdr_ff[HDR_OP_LSB +: 8];
                  xfer_addr_ff <= desc_addr_ff[23:0];
                  xfer_rx_bits_ff <= RX_REG_BITS;
                  state_ff <= SH_QUERY_WAIT;
               end else begin
                  err_ff <= 1'b1;
                  state_ff <= SH_DONE;
               end
            end
            SH_QUERY_WAIT: begin
               if (xfer_done_ff) begin
                  sel_bit_ff <= |(rx_sr_ff[7:0] & hdr_ff[HDR_MASK_LSB +: 8]);
                  state_ff <= SH_EVAL;
               end
            end
            SH_EVAL: begin
               cfg_id_ff <= {cfg_id_ff[1:0], sel_bit_ff};
               det_count_ff <= det_count_ff + 2'h1;
               case (det_idx_ff)
                  2'h0: hybrid_uniform_select_ff <= sel_bit_ff;
                  2'h1: param_sector_top_select_ff <= sel_bit_ff;
                  default: uniform_block_size_select_ff <= sel_bit_ff;
               endcase
               if (hdr_ff[HDR_END_BIT] || det_idx_ff == DET_LAST_IDX) begin
                  state_ff <= SH_DONE;
               end else begin
                  det_idx_ff <= det_idx_ff + 2'h1;
                  state_ff <= SH_FETCH;
               end
            end
            SH_DONE: begin
               done_ff <= 1'b1;
               state_ff <= SH_IDLE;
            end
            default: begin
               state_ff <= SH_IDLE;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // wishbone slave, answers one cycle after the strobe
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h00000000;
      end else begin
         wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
         wb_dat_o <= 32'h00000000;
         if (wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i) begin
            case (wb_adr_i)
               WB_STATUS: wb_dat_o <= {29'h0, err_ff, done_ff, state_ff != SH_IDLE};
               WB_RESULT: wb_dat_o <= {18'h0,
                  uniform_block_size_select_ff,
                  param_sector_top_select_ff && !hybrid_uniform_select_ff,
                  !hybrid_uniform_select_ff,
                  uniform_block_size_select_ff,
                  param_sector_top_select_ff,
                  hybrid_uniform_select_ff,
                  3'h0, det_count_ff, cfg_id_ff};
               WB_DESC_HDR: wb_dat_o <= hdr_ff;
               WB_DESC_ADDR: wb_dat_o <= desc_addr_ff;
               default: wb_dat_o <= 32'h00000000;
            endcase
         end
      end
   end
endmodule : smcd_host

// ### test/smcd_link_checker.sv
// assertions on the serial link joining the detector host and the flash device
`timescale 1ns/100ps
module smcd_link_checker import smcd_pkg::*; (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic mosi,
   input wire logic miso,
   input wire logic miso_oe
);
   // ----------------------------------------------------------------
   // frame tracking
   // ----------------------------------------------------------------
   logic sclk_ff;
   logic cs_n_ff;
   logic [6:0] cnt_ff;
   logic [23:0] sh_ff;
   logic [7:0] op_ff;
   logic [23:0] adr_ff;
   logic rise;
   assign rise = sclk & ~sclk_ff;
   always_ff @(posedge clk_i) begin
      sclk_ff <= rst_i ? 1'b0 : sclk;
      cs_n_ff <= rst_i ? 1'b1 : cs_n;
   end
   // counter cleared only on select fall so it still holds the length at frame end
   always_ff @(posedge clk_i) begin
      if (rst_i || (!cs_n && cs_n_ff)) begin
         cnt_ff <= 7'h00;
      end else if (rise) begin
         cnt_ff <= cnt_ff + 7'h01;
      end
   end
   always_ff @(posedge clk_i) begin
      if (rise) begin
         sh_ff <= {sh_ff[22:0], mosi};
         if (cnt_ff == 7'h07) op_ff <= {sh_ff[6:0], mosi};
         if (cnt_ff == 7'h1F) adr_ff <= {sh_ff[22:0], mosi};
      end
   end
   // ----------------------------------------------------------------
   // properties
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   property p_sclk_idle;
      cs_n |-> !sclk;
   endproperty
   a_sclk_idle: assert property (p_sclk_idle) else $error("clock moves outside frame");
   property p_half_high;
      $rose(sclk) |-> sclk [*8] ##1 !sclk;
   endproperty
   a_half_high: assert property (p_half_high) else $error("clock high phase wrong");
   property p_mosi_hold;
      sclk && $past(sclk) |-> $stable(mosi);
   endproperty
   a_mosi_hold: assert property (p_mosi_hold) else $error("host data moved while clock high");
   property p_opcode;
      cnt_ff == 7'h08 |-> op_ff == 8'h65 || op_ff == CMD_READ_TABLE;
   endproperty
   a_opcode: assert property (p_opcode) else $error("unexpected opcode on link");
   property p_query_addr;
      cnt_ff == 7'h20 && op_ff == 8'h65 |-> adr_ff == 24'h000004 || adr_ff == 24'h000002;
   endproperty
   a_query_addr: assert property (p_query_addr) else $error("query address not 2 or 4");
   property p_reg_len;
      $rose(cs_n) && op_ff == 8'h65 |-> cnt_ff == 7'h30;
   endproperty
   a_reg_len: assert property (p_reg_len) else $error("register read frame length wrong");
   property p_tab_len;
      $rose(cs_n) && op_ff == CMD_READ_TABLE |-> cnt_ff == 7'h68;
   endproperty
   a_tab_len: assert property (p_tab_len) else $error("table read frame length wrong");
   property p_cs_gap;
      $rose(cs_n) |-> cs_n [*8];
   endproperty
   a_cs_gap: assert property (p_cs_gap) else $error("select gap too short");
   property p_oe_data;
      miso_oe |-> cnt_ff >= 7'h28;
   endproperty
   a_oe_data: assert property (p_oe_data) else $error("device drives before data phase");
   property p_oe_idle;
      cs_n [*6] |-> !miso_oe;
   endproperty
   a_oe_idle: assert property (p_oe_idle) else $error("device drives while deselected");
   c_reg_frame: cover property ($rose(cs_n) && op_ff == 8'h65);
   c_tab_frame: cover property ($rose(cs_n) && op_ff == CMD_READ_TABLE);
   c_data_one: cover property (miso_oe && miso);
endmodule : smcd_link_checker

// ### test/sector_map_config_detect_tb.sv
// self-checking bench: host and device joined, host driven over wishbone
`timescale 1ns/100ps
module sector_map_config_detect_tb import smcd_pkg::*; ;
   typedef struct {
      string nm;
      logic [31:0] exp;
      logic [31:0] msk;
   } smcd_exp_s;
   logic clk_i;
   logic rst_i;
   logic wb_cyc;
   logic wb_stb;
   logic wb_we;
   logic [7:0] wb_adr;
   logic [3:0] wb_sel;
   logic [31:0] wb_wdat;
   logic [31:0] wb_rdat;
   logic wb_ack;
   logic cfg_load;
   logic [7:0] first_cfg;
   logic [7:0] third_cfg;
   logic [7:0] last_opcode;
   logic selected;
   logic [31:0] rdat;
   smcd_exp_s mon_e;
   int fails;
   int n_compared;
   smcd_exp_s exp_q[$];
   logic [23:0] adr_q[$];

   smcd_link_if smcd_link_if_i ();
   smcd_host smcd_host_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
      .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat),
      .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .link(smcd_link_if_i.host));
   smcd_device smcd_device_i (.clk_i(clk_i), .rst_i(rst_i), .cfg_load_i(cfg_load),
      .first_cfg_i(first_cfg), .third_cfg_i(third_cfg), .last_opcode_o(last_opcode),
      .selected_o(selected), .link(smcd_link_if_i.device));
   smcd_link_checker smcd_link_checker_i (.clk_i(clk_i), .rst_i(rst_i),
      .sclk(smcd_link_if_i.sclk), .cs_n(smcd_link_if_i.cs_n), .mosi(smcd_link_if_i.mosi),
      .miso(smcd_link_if_i.miso), .miso_oe(smcd_link_if_i.miso_oe));

   // ----------------------------------------------------------------
   // tasks
   // ----------------------------------------------------------------
   task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
      n_compared++;
      if (got !== exp) begin
         fails++;
         $display("Error %s expected %h seen %h", nm, exp, got);
      end
   endtask : check

   // read expectations go to the queue; the monitor compares at ack
   task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat,
                     input string nm, input logic [31:0] exp, input logic [31:0] msk);
      smcd_exp_s e;
      e.nm = nm;
      e.exp = exp;
      e.msk = msk;
      if (!we) exp_q.push_back(e);
      wb_cyc <= 1'b1;
      wb_stb <= 1'b1;
      wb_we <= we;
      wb_sel <= 4'hF;
      wb_adr <= adr;
      wb_wdat <= dat;
      @(posedge clk_i);
      while (wb_ack !== 1'b1) @(posedge clk_i);
      rdat = wb_rdat;
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
      @(posedge clk_i);
   endtask : wb

   task automatic finish_test;
      $display("compared %0d mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : finish_test

   // ----------------------------------------------------------------
   // processes
   // ----------------------------------------------------------------
   initial begin
      clk_i = 1'b0;
      forever #20 clk_i = ~clk_i;
   end

   always @(posedge clk_i) begin
      if (wb_ack === 1'b1 && wb_we === 1'b0) begin
         if (exp_q.size() == 0) begin
            fails++;
            $display("Error read ack expected none seen %h", wb_rdat);
         end else begin
            mon_e = exp_q.pop_front();
            if (mon_e.msk != 32'h0) check(mon_e.nm, mon_e.exp & mon_e.msk, wb_rdat & mon_e.msk);
         end
      end
   end

   // wire view: opcode and address of every frame, msb first
   initial begin : link_mon
      logic [31:0] sh;
      forever begin
         @(negedge smcd_link_if_i.cs_n);
         for (int i = 0; i < 32; i++) begin
            @(posedge smcd_link_if_i.sclk);
            sh = {sh[30:0], smcd_link_if_i.mosi};
         end
         if (sh[31:24] == 8'h65) check("query address", {8'h00, adr_q.pop_front()}, {8'h00, sh[23:0]});
      end
   end

   initial begin
      repeat (90000) @(posedge clk_i);
      fails++;
      $display("Error watchdog expected finish seen hang");
      finish_test();
   end

   initial begin : main
      logic b3;
      logic b2;
      logic b1;
      logic [31:0] res;
      rst_i = 1'b1;
      wb_cyc = 1'b0;
      wb_stb = 1'b0;
      wb_we = 1'b0;
      wb_adr = 8'h00;
      wb_sel = 4'hF;
      wb_wdat = 32'h0;
      cfg_load = 1'b0;
      first_cfg = 8'h00;
      third_cfg = 8'h00;
      void'($urandom(79));
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      wb(1'b1, 8'h20, $urandom, "", 32'h0, 32'h0);
      wb(1'b0, 8'h20, 32'h0, "unmapped", 32'h0, 32'hFFFFFFFF);
      wb(1'b0, WB_STATUS, 32'h0, "idle status", 32'h0, 32'h7);
      $display("test unmapped done");
      for (int k = 0; k < 8; k++) begin
         b3 = k[2];
         b2 = k[1];
         b1 = k[0];
         // select bit 3 and size bit 1 sit in register 4, location bit 2 in register 2
         first_cfg <= 8'($urandom & 32'hFB) | {5'h00, b2, 2'h0};
         third_cfg <= 8'($urandom & 32'hF5) | {4'h0, b3, 1'b0, b1, 1'b0};
         cfg_load <= 1'b1;
         @(posedge clk_i);
         cfg_load <= 1'b0;
         adr_q = '{24'h000004, 24'h000002, 24'h000004};
         wb(1'b1, WB_CTRL, 32'h1, "", 32'h0, 32'h0);
         wb(1'b0, WB_STATUS, 32'h0, "busy status", 32'h1, 32'h7);
         if (k == 5) wb(1'b1, WB_CTRL, 32'h1, "", 32'h0, 32'h0);
         do wb(1'b0, WB_STATUS, 32'h0, "", 32'h0, 32'h0); while (rdat[1] !== 1'b1);
         res = {18'h0, b1, ~b3 & b2, ~b3, b1, b2, b3, 3'h0, 2'h3, b3, b2, b1};
         wb(1'b0, WB_STATUS, 32'h0, "done status", 32'h2, 32'h7);
         wb(1'b0, WB_RESULT, 32'h0, "result", res, 32'h3FFF);
         wb(1'b0, WB_DESC_HDR, 32'h0, "last header", 32'h02FF65FD, 32'hFFFFFFFF);
         wb(1'b0, WB_DESC_ADDR, 32'h0, "last address", 32'h4, 32'hFFFFFFFF);
         check("last opcode", 32'h65, {24'h0, last_opcode});
         check("deselected", 32'h0, {31'h0, selected});
         check("queries left", 32'h0, 32'(adr_q.size()));
         $display("test detect %0d done", k);
      end
      finish_test();
   end
endmodule : sector_map_config_detect_tb
